// ==== hdl/brc_map.svh ====
// Constants for the fourteen-stage binary counter.
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH
`define BRC_STAGES 14
`define BRC_UPPER_FIRST 4
`define BRC_UPPER_COUNT 11
`endif

// ==== hdl/brc_pkg.sv ====
// Types shared by the binary counter files.
package brc_pkg;
   typedef struct packed {
      logic [10:0] upper_stage_outputs;
      logic first_stage_output;
   } brc_outputs_type;
endpackage

// ==== hdl/brc_edge_sync.sv ====
// Two-flop synchroniser with falling-edge detector for the count clock pin.
`timescale 1ns/1ps
module brc_edge_sync (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic pin_i,
   output logic fall_o
);
   logic meta;
   logic sync;
   logic last;
   logic next_fall;

   always_comb begin
      next_fall = last & ~sync;
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         meta <= pin_i;
         sync <= meta;
         last <= sync;
         fall_o <= next_fall;
      end
   end
endmodule

// ==== hdl/brc_counter.sv ====
// Fourteen-stage binary counter advanced by falling edges of a sampled clock pin.
`timescale 1ns/1ps
`include "brc_map.svh"
// Overview of operation
// - With reset low, each falling edge of the count clock advances the count by one.
// - While reset is high the count is held at zero, cleared on the system clock after a two-flop synchroniser.
// - Stage output N toggles at the count clock rate divided by two to the N.
// - Only stage one and stages four to fourteen are brought out as active-high outputs.
// - The counter has fourteen stages, all registered on the system clock; a stage flips when every lower stage is one.
module brc_counter #(
   parameter int STAGES = `BRC_STAGES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic count_clk_i,
   input wire logic count_rst_i,
   output brc_pkg::brc_outputs_type stage_output_o
);
   // ****************************************
   // Input sampling
   // ****************************************
   logic fall;
   logic rst_meta;
   logic rst_sync;

   brc_edge_sync u_clk_sync (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(count_clk_i),
      .fall_o(fall)
   );

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= count_rst_i;
         rst_sync <= rst_meta;
      end
   end

   // ****************************************
   // Count stages
   // ****************************************
   logic [STAGES-1:0] count;
   logic [STAGES-1:0] next_count;
   logic [STAGES-1:0] toggle_mask;
   brc_pkg::brc_outputs_type next_out;

   // Returns the stages that flip on one count: a stage flips when every lower stage is one,
   // which is what a chain of stages each clocked by its neighbour would do.
   function automatic logic [STAGES-1:0] stage_flips(logic [STAGES-1:0] value);
      logic [STAGES-1:0] flips;
      logic carry;
      flips = '0;
      carry = 1'b1;
      for (int k = 0; k < STAGES; k++) begin
         flips[k] = carry;
         carry = carry & value[k];
      end
      return flips;
   endfunction

   // Picks the stages that are brought out from a full count value.
   function automatic brc_pkg::brc_outputs_type pin_view(logic [STAGES-1:0] value);
      brc_pkg::brc_outputs_type view;
      view.first_stage_output = value[0];
      view.upper_stage_outputs = value[`BRC_UPPER_FIRST-1 +: `BRC_UPPER_COUNT];
      return view;
   endfunction

   always_comb begin
      toggle_mask = stage_flips(count);
      next_count = count;
      if (rst_sync) begin
         next_count = '0;
      end else if (fall) begin
         next_count = count ^ toggle_mask;
      end
      next_out = pin_view(next_count);
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         count <= '0;
         stage_output_o <= '0;
      end else begin
         count <= next_count;
         stage_output_o <= next_out;
      end
   end

   // ****************************************
   // Reference count
   // ****************************************
   // A plain adder kept beside the stage chain, so the checks do not trust the chain itself.
   logic [STAGES-1:0] ref_count;
   logic [STAGES-1:0] next_ref_count;

   always_comb begin
      next_ref_count = ref_count;
      if (rst_sync) begin
         next_ref_count = '0;
      end else if (fall) begin
         next_ref_count = ref_count + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ref_count <= '0;
      end else begin
         ref_count <= next_ref_count;
      end
   end

   // ****************************************
   // Reset checks
   // ****************************************
   a_reset_clears: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rst_sync |=> (stage_output_o == '0))
      else $error("output not zero in reset");

   // The system reset clears the outputs without waiting for a clock edge.
   a_sys_reset_low: assert property (@(posedge sys_clk_i)
      sys_rst_i |-> (stage_output_o == '0))
      else $error("output not zero in system reset");

   a_pin_reset_count: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rst_sync |=> (count == '0))
      else $error("count not zero in reset");

   // A fall that meets the pin reset is dropped, so the reset wins.
   a_reset_wins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (rst_sync && fall) |=> (count == '0))
      else $error("fall beat the reset");

   // ****************************************
   // Count checks
   // ****************************************
   a_fall_advances: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (fall && !rst_sync) |=> (count == $past(count) + 1'b1))
      else $error("count did not advance");

   // Rising edges and steady levels make no fall pulse, so the count must stand.
   a_hold_no_edge: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!fall && !rst_sync) |=> $stable(count))
      else $error("count moved without edge");

   a_wrap_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (fall && !rst_sync && &count) |=> (count == '0))
      else $error("no wrap");

   a_stage_toggle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (fall && !rst_sync && count[2:0] == 3'h7) |=> (count[3] != $past(count[3])))
      else $error("stage four did not toggle");

   // An even count moves only the first stage; nothing above it may follow.
   a_stage_ripple: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (fall && !rst_sync && count[0] == 1'b0) |=> (count[STAGES-1:1] == $past(count[STAGES-1:1])))
      else $error("upper stages changed early");

   a_single_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (fall && !rst_sync) |=> ((count ^ $past(count)) == stage_flips($past(count))))
      else $error("wrong stages flipped");

   // The first stage halves the count clock, so it flips on every counted fall.
   a_first_stage_rate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (fall && !rst_sync) |=> (count[0] != $past(count[0])))
      else $error("first stage did not flip");

   a_top_stage_toggle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (fall && !rst_sync && &count[STAGES-2:0]) |=> (count[STAGES-1] != $past(count[STAGES-1])))
      else $error("top stage did not toggle");

   // One pin fall must yield exactly one count pulse.
   a_fall_pulse_once: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      fall |=> !fall)
      else $error("fall pulse longer than one cycle");

   a_ref_count_match: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (count == ref_count))
      else $error("count differs from reference");

   // ****************************************
   // Output checks
   // ****************************************
   a_outputs_map: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ##1 (stage_output_o.first_stage_output == $past(next_count[0]) || $past(rst_sync)))
      else $error("first stage mismatch");

   a_upper_map: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (stage_output_o.upper_stage_outputs == count[13:3]))
      else $error("upper stage mismatch");

   // The outputs must always show the reference count, stages two and three left out.
   a_output_view: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (stage_output_o == pin_view(ref_count)))
      else $error("outputs differ from reference");

   // ****************************************
   // Coverage
   // ****************************************
   c_wrap: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      fall && &count);
   c_reset: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rst_sync && count != '0);
   c_advance: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      fall && !rst_sync);
   c_reset_release: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rst_sync ##1 !rst_sync);
   c_upper_carry: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      fall && !rst_sync && count[2:0] == 3'h7);
endmodule

// ==== tb/brc_far_end.sv ====
// Clock source and time-base decoder facing the counter outputs.
`timescale 1ns/1ps
module brc_far_end (
   input wire logic sys_clk_i,
   input wire logic run_i,
   input wire logic dec_en_i,
   input brc_pkg::brc_outputs_type stage_i,
   output logic count_clk_o,
   output logic count_rst_o
);
   logic [1:0] ph = 2'h0;
   initial count_clk_o = 1'b1;
   always @(posedge sys_clk_i) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) count_clk_o <= run_i ? ~count_clk_o : 1'b1;
   end
   // Outputs are registered together, so the decode needs no clock gating.
   assign count_rst_o = dec_en_i & stage_i[2] & stage_i[7] & stage_i[8] & stage_i[9];
endmodule

// ==== tb/brc_counter_tb.sv ====
// Self-checking bench for the fourteen-stage counter.
`timescale 1ns/1ps
module brc_counter_tb;
   logic sys_clk = 1'b0, sys_rst = 1'b1, run = 1'b0, dec_en = 1'b0, prev = 1'b1;
   wire logic cclk, crst;
   brc_pkg::brc_outputs_type q;
   int miscompares = 0, total_checks = 0, falls = 0;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      prev <= cclk;
      if (prev && !cclk) falls <= falls + 1;
   end
   brc_counter u_brc_counter(.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .count_clk_i(cclk),
      .count_rst_i(crst), .stage_output_o(q));
   brc_far_end u_brc_far_end(.sys_clk_i(sys_clk), .run_i(run), .dec_en_i(dec_en),
      .stage_i(q), .count_clk_o(cclk), .count_rst_o(crst));
   // ****
   // Helpers.
   // ****
   function automatic logic [11:0] pins(logic [13:0] n);
      return {n[13:3], n[0]};
   endfunction
   task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_falls(int n);
      run <= 1'b1;
      for (int i = 0; i < 2000 && falls < n; i++) @(posedge sys_clk);
      if (falls < n) begin
         miscompares++;
         wrap_up();
      end
      run <= 1'b0;
      repeat (8) @(posedge sys_clk);
      check("count", q, pins(n[13:0]));
      $display("count test %0d done", n);
   endtask
   task automatic t_timebase;
      dec_en <= 1'b1;
      run <= 1'b1;
      for (int i = 0; i < 40000 && crst !== 1'b1; i++) @(posedge sys_clk);
      if (crst !== 1'b1) begin
         miscompares++;
         wrap_up();
      end
      check("decode", q, pins(14'hE10));
      run <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 check("pin reset", q, 12'h000);
      $display("time-base test done");
   endtask
   task automatic t_power_up;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1 check("after reset", q, 12'h000);
      $display("power-up test done");
   endtask
   task automatic t_async_clear;
      @(posedge sys_clk) sys_rst <= 1'b1;
      #1 check("async clear", q, 12'h000);
      @(posedge sys_clk) sys_rst <= 1'b0;
      @(posedge sys_clk);
      #1 check("after release", q, 12'h000);
      $display("async clear test done");
   endtask
   initial begin
      t_power_up();
      wait_falls(11);
      wait_falls(37);
      t_async_clear();
      t_timebase();
      wrap_up();
   end
endmodule
